/* File: logic/uart_tx_trigger_second_xoff_character_regs.sv */
`timescale 1ns/10ps
// Behaviour
// - Transmit-ready raised when free entries >= four times trigger nibble.
// - Zero nibble selects trigger level from FIFO control bits five and four.
// - Second Xoff register at offset 7 only when line control 0xBF, unlock not 0x5A.
// - Second Xoff register holds full eight bits, host readable and writable.
// - Second Xoff register cleared only by power-on reset, not software reset.
module uart_tx_trigger_second_xoff_character_regs
    import uart_trig_pkg::*;
#(
    parameter int FREE_WIDTH = FREE_W
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_sw_rst,
    input  wire reg_req_t              i_req,
    input  wire logic [7:0]            i_line_control_reg,
    input  wire logic [7:0]            i_special_function_unlock,
    input  wire logic [1:0]            i_fifo_control_tx_sel,
    input  wire logic [FREE_WIDTH-1:0] i_tx_free,
    output logic [7:0]                 o_rdata,
    output logic                       o_rvalid,
    output logic [7:0]                 o_second_xoff_character,
    output logic [7:0]                 o_fifo_trigger_level,
    output logic                       o_tx_ready_irq
);

    logic       rst_n;
    logic [7:0] sec_xoff_r;
    logic [7:0] trig_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       irq_r;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    rst_sync #(
        .STAGES (RST_STAGES)
    ) u_rst_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .o_rstn (rst_n)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire       sec_xoff_open = (i_line_control_reg == LINE_CTL_OPEN) &&
                               (i_special_function_unlock != UNLOCK_KEY);
    wire       hit_sec_xoff  = (i_req.addr == SEC_XOFF_OFFSET) && sec_xoff_open;
    wire       hit_trig      = (i_req.addr == TRIG_OFFSET);
    wire       wr_sec_xoff   = i_req.wr && hit_sec_xoff;
    wire       wr_trig       = i_req.wr && hit_trig;
    wire [7:0] rd_mux        = hit_sec_xoff ? sec_xoff_r :
                               hit_trig     ? trig_r     : 8'h00;

    // ****************************************************************
    // Trigger level selection
    // ****************************************************************
    wire [3:0]            tx_nib    = trig_r[TX_NIB_MSB:TX_NIB_LSB];
    wire [6:0]            nib_level = 7'(tx_nib) << TRIG_SHIFT;
    wire [6:0]            sel_level = (i_fifo_control_tx_sel == 2'h0) ? TX_LVL_SEL0 :
                                      (i_fifo_control_tx_sel == 2'h1) ? TX_LVL_SEL1 :
                                      (i_fifo_control_tx_sel == 2'h2) ? TX_LVL_SEL2 :
                                                                        TX_LVL_SEL3;
    // Zero nibble falls back to the control field level
    wire [6:0]            tx_level  = (tx_nib == 4'h0) ? sel_level : nib_level;
    wire [FREE_WIDTH-1:0] level_ext = FREE_WIDTH'(tx_level);
    wire                  tx_ready  = (i_tx_free >= level_ext);

    // ****************************************************************
    // Second Xoff character, power-on reset only
    // ****************************************************************
    // Software reset kept away so the flow-control character survives it
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_xoff_r <= SEC_XOFF_RESET;
        end else if (wr_sec_xoff) begin
            sec_xoff_r <= i_req.wdata;
        end
    end

    // ****************************************************************
    // Trigger level register, also cleared by software reset
    // ****************************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_r <= TRIG_RESET;
        end else if (i_sw_rst) begin
            trig_r <= TRIG_RESET;
        end else if (wr_trig) begin
            trig_r <= i_req.wdata;
        end
    end

    // ****************************************************************
    // Read data and interrupt condition
    // ****************************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_req.rd;
            if (i_req.rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= tx_ready;
        end
    end

    assign o_rdata                 = rdata_r;
    assign o_rvalid                = rvalid_r;
    assign o_second_xoff_character = sec_xoff_r;
    assign o_fifo_trigger_level    = trig_r;
    assign o_tx_ready_irq          = irq_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_irq_nibble_level:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (trig_r[3:0] != 4'h0) |=>
            (o_tx_ready_irq == ($past(i_tx_free) >= FREE_WIDTH'({$past(trig_r[3:0]), 2'b00}))))
    else $error("transmit ready does not follow four times the nibble");

    a_irq_fcr_select:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (trig_r[3:0] == 4'h0 && i_fifo_control_tx_sel == 2'h3 && i_tx_free < 7'h38) |=>
            !o_tx_ready_irq)
    else $error("zero nibble does not use the control field level");

    // ****************************************************************
    // Second Xoff mapping and storage
    // ****************************************************************
    a_sec_xoff_open:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_req.wr && i_req.addr == 4'h7 && i_line_control_reg == 8'hBF &&
         i_special_function_unlock != 8'h5A) |=> (sec_xoff_r == $past(i_req.wdata)))
    else $error("open second Xoff write not stored");

    a_sec_xoff_shut:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_line_control_reg != 8'hBF || i_special_function_unlock == 8'h5A) |=>
            $stable(sec_xoff_r))
    else $error("second Xoff changed while not mapped");

    a_sec_xoff_locked:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_req.rd && i_req.addr == 4'h7 &&
         (i_line_control_reg != 8'hBF || i_special_function_unlock == 8'h5A)) |=>
            (o_rvalid && o_rdata == 8'h00))
    else $error("locked second Xoff read not zero");

    a_sec_xoff_read:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_req.rd && !i_req.wr && hit_sec_xoff) |=> (o_rvalid && o_rdata == sec_xoff_r))
    else $error("second Xoff read returns wrong value");

    a_sec_xoff_swrst:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_sw_rst && !wr_sec_xoff) |=> $stable(sec_xoff_r))
    else $error("software reset disturbed second Xoff");

    // No disable here, so that the power-on clear itself is seen
    a_sec_xoff_por:
    assert property (@(posedge i_clk)
        !rst_n |-> (sec_xoff_r == 8'h00))
    else $error("power-on reset left second Xoff set");

    // ****************************************************************
    // Read strobe answer
    // ****************************************************************
    a_rvalid_after_read:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        i_req.rd |=> o_rvalid)
    else $error("read strobe not answered");

    a_rvalid_one_pulse:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        !i_req.rd |=> !o_rvalid)
    else $error("read valid without a read strobe");

    // ****************************************************************
    // Transmit-ready tracking
    // ****************************************************************
    a_irq_nibble_low:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (trig_r[3:0] != 4'h0 && i_tx_free < FREE_WIDTH'({trig_r[3:0], 2'h0})) |=> !o_tx_ready_irq)
    else $error("transmit ready raised below four times the nibble");

    a_irq_nibble_reach:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (trig_r[3:0] != 4'h0 && i_tx_free >= FREE_WIDTH'({trig_r[3:0], 2'h0})) |=> o_tx_ready_irq)
    else $error("transmit ready missing at four times the nibble");

    a_irq_fcr_reach:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (trig_r[3:0] == 4'h0 && i_fifo_control_tx_sel == 2'h1 &&
         i_tx_free >= FREE_WIDTH'(TX_LVL_SEL1)) |=> o_tx_ready_irq)
    else $error("zero nibble misses the control field level");

    a_irq_drop_below:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (o_tx_ready_irq && trig_r[3:0] != 4'h0 &&
         i_tx_free < FREE_WIDTH'({trig_r[3:0], 2'h0})) |=> !o_tx_ready_irq)
    else $error("transmit ready held below trigger level");

    a_irq_rise_above:
    assert property (@(posedge i_clk) disable iff (!rst_n)
        (!o_tx_ready_irq && trig_r[3:0] == 4'h0 && i_fifo_control_tx_sel == 2'h0 &&
         i_tx_free >= FREE_WIDTH'(TX_LVL_SEL0)) |=> o_tx_ready_irq)
    else $error("transmit ready missing at trigger level");

endmodule // uart_tx_trigger_second_xoff_character_regs

/* File: logic/uart_trig_pkg.sv */
package uart_trig_pkg;

    // ****************************************************************
    // Register offsets and reset values
    // ****************************************************************
    localparam logic [3:0] SEC_XOFF_OFFSET = 4'h7;
    localparam logic [3:0] TRIG_OFFSET     = 4'hE;
    localparam logic [7:0] SEC_XOFF_RESET  = 8'h00;
    localparam logic [7:0] TRIG_RESET      = 8'h00;

    // ****************************************************************
    // Access condition for the second Xoff register
    // ****************************************************************
    localparam logic [7:0] LINE_CTL_OPEN  = 8'hBF;
    localparam logic [7:0] UNLOCK_KEY     = 8'h5A;

    // ****************************************************************
    // Field positions and scaling
    // ****************************************************************
    localparam int         TX_NIB_LSB     = 0;
    localparam int         TX_NIB_MSB     = 3;
    localparam int         TRIG_SHIFT     = 2;
    localparam int         FREE_W         = 7;

    // ****************************************************************
    // Fixed transmit trigger levels picked by the FIFO control field
    // ****************************************************************
    localparam logic [6:0] TX_LVL_SEL0    = 7'h08;
    localparam logic [6:0] TX_LVL_SEL1    = 7'h10;
    localparam logic [6:0] TX_LVL_SEL2    = 7'h20;
    localparam logic [6:0] TX_LVL_SEL3    = 7'h38;

    localparam int         RST_STAGES     = 2;

    typedef struct packed {
        logic [3:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* File: logic/rst_sync.sv */
`timescale 1ns/10ps
module rst_sync #(
    parameter int STAGES = 2
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    output logic      o_rstn
);

    logic [STAGES-1:0] shift_r;

    // ****************************************************************
    // Asynchronous assert, synchronous release
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_r <= '0;
        end else begin
            shift_r <= {shift_r[STAGES-2:0], 1'b1};
        end
    end

    assign o_rstn = shift_r[STAGES-1];

endmodule // rst_sync

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top
    import uart_trig_pkg::*;
();
    // ****************************************************************
    // Stimulus and expectation queues
    // ****************************************************************
    logic       clk, por_n, sw_rst, rvalid, irq;
    reg_req_t   req;
    logic [7:0] line_ctl, unlock, rdata, d, xoff_out, trig_out;
    logic [1:0] sel;
    logic [6:0] free;
    logic [3:0] nib;
    logic [7:0] rd_q[$];
    logic       irq_q[$];
    logic [6:0] lv[4] = '{TX_LVL_SEL0, TX_LVL_SEL1, TX_LVL_SEL2, TX_LVL_SEL3};
    int         bad_count = 0, n_tests = 0, cycles = 0, seed;

    uart_tx_trigger_second_xoff_character_regs DUT (.i_clk(clk), .i_rstn(por_n), .i_sw_rst(sw_rst),
        .i_req(req), .i_line_control_reg(line_ctl), .i_special_function_unlock(unlock),
        .i_fifo_control_tx_sel(sel), .i_tx_free(free), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_second_xoff_character(xoff_out), .o_fifo_trigger_level(trig_out),
        .o_tx_ready_irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end

    task cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task cmp1(input string what, input logic e, input logic s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, e, s);
        end
    endtask

    // Watches outputs just after each rising edge
    always @(posedge clk) begin
        #1;
        if (rvalid === 1'b1) begin
            if (rd_q.size() == 0) cmp1("read valid", 1'b0, rvalid);
            else cmp8("read data", rd_q.pop_front(), rdata);
        end
        if (irq_q.size() != 0) cmp1("tx ready irq", irq_q.pop_front(), irq);
    end

    task put(input logic [3:0] a, input logic w, input logic r, input logic [7:0] wd);
        @(negedge clk);
        req = {a, w, r, wd};
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        put(a, 1'b0, 1'b1, 8'h00);
        rd_q.push_back(e);
    endtask
    task idle;
        put(4'h0, 1'b0, 1'b0, 8'h00);
    endtask
    task chk_free(input logic [6:0] f);
        @(negedge clk);
        free = f;
        irq_q.push_back(f >= ((nib == 4'h0) ? lv[sel] : {1'b0, nib, 2'b00}));
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 32'h49AB44AA;
        req = '0; por_n = 1'b0; sw_rst = 1'b0; line_ctl = 8'hBF; unlock = 8'h00;
        sel = 2'h0; free = 7'h00; nib = 4'h0;
        repeat (2) @(negedge clk);
        por_n = 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h7, 8'h00);
        rd(TRIG_OFFSET, TRIG_RESET);
        repeat (4) begin
            d = $random(seed);
            put(4'h7, 1'b1, 1'b0, d);
            rd(4'h7, d);
        end
        put(4'h7, 1'b1, 1'b1, 8'hA5);
        rd_q.push_back(d);
        rd(4'h7, 8'hA5);
        for (int k = 0; k < 2; k++) begin
            idle;
            {line_ctl, unlock} = k ? {8'h03, 8'h00} : {8'hBF, 8'h5A};
            put(4'h7, 1'b1, 1'b0, 8'h3C);
            rd(4'h7, 8'h00);
        end
        idle;
        {line_ctl, unlock} = {8'hBF, 8'h00};
        rd(4'h7, 8'hA5);
        cmp8("xoff output", 8'hA5, xoff_out);
        put(TRIG_OFFSET, 1'b1, 1'b0, 8'h35);
        idle;
        cmp8("trigger output", 8'h35, trig_out);
        sw_rst = 1'b1;
        idle;
        sw_rst = 1'b0;
        cmp8("trigger output", 8'h00, trig_out);
        cmp8("xoff output", 8'hA5, xoff_out);
        rd(TRIG_OFFSET, 8'h00);
        rd(4'h7, 8'hA5);
        for (int n = 1; n < 16; n++) begin
            nib = 4'(n);
            put(TRIG_OFFSET, 1'b1, 1'b0, {4'($random(seed)), nib});
            idle;
            chk_free(7'(4 * n - 1));
            chk_free(7'(4 * n));
            chk_free(7'h40);
            chk_free(7'(4 * n - 1));
        end
        nib = 4'h0;
        put(TRIG_OFFSET, 1'b1, 1'b0, 8'h00);
        for (int s = 0; s < 4; s++) begin
            idle;
            sel = 2'(s);
            chk_free(lv[s] - 7'h01);
            chk_free(lv[s]);
        end
        idle;
        por_n = 1'b0;
        idle;
        por_n = 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h7, 8'h00);
        cmp8("xoff output", 8'h00, xoff_out);
        idle;
        repeat (3) @(negedge clk);
        cmp8("pending reads", 8'h00, 8'(rd_q.size()));
        give_verdict();
    end
endmodule // tb_top
